// ### rtl/dls_status_readout.sv
// Link status, AGC tap and noise margin readout over Avalon-MM
//
// Contract
// - Deactivation-done set on timer expiry to deactivated
// - Deactivation-done rise interrupts unless masked
// - Deactivation-done read-clears, persists while deactivated
// - Pending-deactivation bit set entering pending state
// - Pending-deactivation rise interrupts unless masked
// - Pending bit read-clears, persists while pending
// - Link-active bit set entering active state
// - Link-active rise interrupts unless masked
// - Link-active bit read-clears, persists while active
// - AGC register: tap top bits, sign zero
// - AGC bits weigh 1 down to 1/64
// - Noise margin readable, refreshed every 64 baud
// - Noise margin signed byte, half-dB steps
// - Noise margin computed, fed to state machine
// - AGC at 0001, noise at 0010, read-only
// - Status bits mirror dedicated status pins
// - Gain low nibble all ones boosts 6 dB
`timescale 1ns/1ps

module dls_status_readout
	import dls_pkg::*;
#(
	parameter int TAP_W = 16,
	parameter int EN_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// From activation controller and receiver
	input wire dls_link_t link_state,
	input wire logic deact_timer_expired,
	input wire logic baud_tick,
	input wire logic [TAP_W-1:0] agc_tap_main,
	input wire logic [EN_W-1:0] rx_signal_energy,
	input wire logic [EN_W-1:0] rx_error_energy,
	// Event request, status pins, gain and margin outputs
	output logic irq,
	output logic deactivation_done_pin,
	output logic pending_deactivation_pin,
	output logic link_active_pin,
	output logic rx_gain_boost,
	output logic [7:0] noise_margin_fsm
);

	// Parameter sanity
	generate
		if (TAP_W < 8 || EN_W < 2 || EN_W > 64) begin : g_bad
			$error("dls_status_readout: unsupported width");
		end
	endgenerate

	// Request bundle
	dls_av_req_t req;
	// Register index and its validity
	logic [3:0] idx;
	logic idx_ok;
	// Accept edge: request seen with waitrequest low
	logic done;
	// Latched events and masks
	dls_evt_t status_reg, status_next;
	dls_evt_t set_now, hold_now, clr_now;
	logic [7:0] event_mask_register;
	logic [7:0] receiver_gain_register;
	// Bits that the pending read returned, cleared on completion
	dls_evt_t read_bits_reg;
	// Previous link state for entry detection
	dls_link_t prev_state_reg;
	// Readout registers, undefined-by-spec so reset to zero here
	logic [7:0] agc_tap_value;
	logic [7:0] noise_margin;
	// Baud counter for noise margin refresh
	logic [5:0] baud_cnt_reg;
	// Log estimates and margin arithmetic
	logic [7:0] lg_sig, lg_err;
	logic signed [9:0] nm_raw;
	logic [7:0] nm_code;
	// Combined read mux
	logic [7:0] rd_mux;

	assign req = '{address, read, write, writedata, byteenable};
	// Byte address; low two bits ignored for word access
	assign idx = req.address[5:2];
	assign idx_ok = (req.address[7:6] == 2'b00);
	assign done = (req.read | req.write) & ~waitrequest;

	// Half-octave log2 estimate: twice the leading one plus next bit
	function automatic logic [7:0] log2h(input logic [EN_W-1:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 1; i < EN_W; i++) begin
			if (v[i]) begin
				r = 8'((2 * i) + int'(v[i-1]));
			end
		end
		return r;
	endfunction : log2h

	// Waitrequest: one stall cycle, then answer; high when idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else if ((req.read | req.write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// Read mux; unmapped and write-only indices read zero
	always_comb begin
		rd_mux = 8'h00;
		if (idx_ok) begin
			case (idx)
				DLS_IDX_STATUS: rd_mux = {5'h00, status_reg};
				DLS_IDX_AGC: rd_mux = agc_tap_value;
				DLS_IDX_NOISE: rd_mux = noise_margin;
				default: rd_mux = 8'h00;
			endcase
		end
	end

	// Read data captured during the stall cycle, stands to completion
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
			read_bits_reg <= '0;
		end else if (req.read && waitrequest) begin
			readdata <= {24'h00_0000, rd_mux};
			if (idx_ok && idx == DLS_IDX_STATUS) begin
				read_bits_reg <= status_reg;
			end else begin
				read_bits_reg <= '0;
			end
		end
	end

	// Writable control; read-only indices ignore writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			event_mask_register <= DLS_MASK_RST;
			receiver_gain_register <= DLS_GAIN_RST;
		end else if (done && req.write && idx_ok && req.byteenable[0]) begin
			if (idx == DLS_IDX_MASK) begin
				event_mask_register <= req.writedata[7:0];
			end
			if (idx == DLS_IDX_GAIN) begin
				receiver_gain_register <= req.writedata[7:0];
			end
		end
	end

	// State history for entry detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_state_reg <= DLS_INACTIVE;
		end else begin
			prev_state_reg <= link_state;
		end
	end

	// Set, hold and clear terms of the status bits
	always_comb begin
		set_now.deact_done = deact_timer_expired
			&& prev_state_reg == DLS_PENDING
			&& link_state == DLS_DEACTIVATED;
		set_now.pend_deact = link_state == DLS_PENDING
			&& prev_state_reg != DLS_PENDING;
		set_now.link_up = link_state == DLS_ACTIVE
			&& prev_state_reg != DLS_ACTIVE;
		hold_now.deact_done = link_state == DLS_DEACTIVATED;
		hold_now.pend_deact = link_state == DLS_PENDING;
		hold_now.link_up = link_state == DLS_ACTIVE;
		// Only bits this read returned are cleared
		clr_now = (done && req.read) ? read_bits_reg : '0;
		// set and hold win over the read-clear
		status_next = (status_reg & ~clr_now) | set_now | hold_now;
	end

	// Latched status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	// pins follow the same latched status bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			deactivation_done_pin <= 1'b0;
			pending_deactivation_pin <= 1'b0;
			link_active_pin <= 1'b0;
		end else begin
			deactivation_done_pin <= status_next.deact_done;
			pending_deactivation_pin <= status_next.pend_deact;
			link_active_pin <= status_next.link_up;
		end
	end

	// Interrupt request; high while any next-state status bit is set and unmasked, with no rise needed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			// deact gated by mask; pending gated; active gated
			// level until all unmasked bits read away
			irq <= (status_next.deact_done
				& ~event_mask_register[DLS_BIT_DEACT])
				| (status_next.pend_deact
				& ~event_mask_register[DLS_BIT_PEND])
				| (status_next.link_up
				& ~event_mask_register[DLS_BIT_LINK_UP]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_gain_boost <= 1'b0;
		end else begin
			rx_gain_boost <= receiver_gain_register[3:0] == DLS_GAIN_BOOST;
		end
	end

	// AGC tap sampled each baud so reads see a settled value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			agc_tap_value <= 8'h00;
		end else if (baud_tick) begin
			// top bits, sign forced to zero
			// B6 weighs 1, B0 weighs 1/64
			agc_tap_value <= {1'b0, agc_tap_main[TAP_W-2 -: 7]};
		end
	end

	// Baud counter for the margin refresh
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			baud_cnt_reg <= 6'h00;
		end else if (baud_tick) begin
			baud_cnt_reg <= baud_cnt_reg + 6'h01;
		end
	end

	// Margin estimate: signal to error ratio in half-dB units
	always_comb begin
		lg_sig = log2h(rx_signal_energy);
		lg_err = log2h(rx_error_energy);
		// log ratio from received signal and error
		nm_raw = 10'(signed'({2'b00, lg_sig}) - signed'({2'b00, lg_err}));
		nm_raw = 10'(nm_raw * signed'(DLS_NM_STEP));
		// clamp into a signed byte, LSB is 0.5 dB
		if (nm_raw > DLS_NM_MAX) begin
			nm_code = DLS_NM_MAX[7:0];
		end else if (nm_raw < DLS_NM_MIN) begin
			nm_code = DLS_NM_MIN[7:0];
		end else begin
			nm_code = nm_raw[7:0];
		end
	end

	// Margin register; the reading is not gain-corrected, software is
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			noise_margin <= 8'h00;
			noise_margin_fsm <= 8'h00;
		end else if (baud_tick && baud_cnt_reg == DLS_NM_LAST) begin
			noise_margin <= nm_code;
			// same value to the activation controller
			noise_margin_fsm <= nm_code;
		end
	end

endmodule : dls_status_readout

// ### rtl/dls_pkg.sv
// Shared constants and types for the link status readout block
package dls_pkg;

	// Register indices; byte address is four times the index
	localparam logic [3:0] DLS_IDX_STATUS = 4'h0;
	localparam logic [3:0] DLS_IDX_AGC = 4'h1;
	localparam logic [3:0] DLS_IDX_NOISE = 4'h2;
	localparam logic [3:0] DLS_IDX_MASK = 4'h8;
	localparam logic [3:0] DLS_IDX_GAIN = 4'h9;

	// Field positions in status and mask registers
	localparam int DLS_BIT_LINK_UP = 0;
	localparam int DLS_BIT_PEND = 1;
	localparam int DLS_BIT_DEACT = 2;

	// Reset values of writable registers
	localparam logic [7:0] DLS_MASK_RST = 8'h00;
	localparam logic [7:0] DLS_GAIN_RST = 8'h00;

	// Gain field: all four low bits set means 6 dB boost
	localparam logic [3:0] DLS_GAIN_BOOST = 4'hF;

	// Noise margin refresh period, in baud periods
	localparam int DLS_NM_BAUDS = 64;
	localparam logic [5:0] DLS_NM_LAST = 6'(DLS_NM_BAUDS - 1);

	// Half-dB units per half octave of power ratio (about 1.5 dB)
	localparam logic [9:0] DLS_NM_STEP = 10'h003;

	// Clamp limits of the signed noise margin byte
	localparam logic signed [9:0] DLS_NM_MAX = 10'sh07F;
	localparam logic signed [9:0] DLS_NM_MIN = -10'sh080;

	// Link states reported by the activation controller, Gray order
	typedef enum logic [2:0] {
		DLS_INACTIVE = 3'h0,
		DLS_ACTIVATING = 3'h1,
		DLS_ACTIVE = 3'h3,
		DLS_PENDING = 3'h2,
		DLS_DEACTIVATED = 3'h6
	} dls_link_t;

	// The three latched link events
	typedef struct packed {
		logic deact_done;
		logic pend_deact;
		logic link_up;
	} dls_evt_t;

	// Avalon request bundle as seen by the slave
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} dls_av_req_t;

endpackage : dls_pkg

// ### verification/dls_status_readout_asserts.sv
// Port checker for the link status readout
`timescale 1ns/1ps
module dls_status_readout_asserts
	import dls_pkg::*;
(
	// Clock, reset and bus
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Link side and outputs
	input wire dls_link_t link_state,
	input wire logic deact_timer_expired,
	input wire logic irq,
	input wire logic deactivation_done_pin,
	input wire logic pending_deactivation_pin,
	input wire logic link_active_pin,
	input wire logic rx_gain_boost
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Status read taken while link idle, so nothing persists
	sequence s_rd_idle;
		read && address == 8'h00 && !waitrequest
			&& link_state == DLS_INACTIVE && $past(link_state) == DLS_INACTIVE;
	endsequence
	a_wait_one: assert property (!waitrequest |=> waitrequest)
		else $error("stall answer lasted two cycles");
	a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
		else $error("answer without request");
	a_rd_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_up_set: assert property (link_state == DLS_ACTIVE |=> link_active_pin)
		else $error("active bit not set");
	a_pend_set: assert property (link_state == DLS_PENDING |=> pending_deactivation_pin)
		else $error("pending bit not set");
	a_deact_set: assert property (deact_timer_expired && link_state == DLS_DEACTIVATED
		&& $past(link_state) == DLS_PENDING |=> deactivation_done_pin)
		else $error("deactivation bit not set");
	a_deact_hold: assert property (deactivation_done_pin
		&& link_state == DLS_DEACTIVATED |=> deactivation_done_pin)
		else $error("deactivation bit lost");
	a_idle_clr: assert property (s_rd_idle |=> !link_active_pin
		&& !pending_deactivation_pin && !deactivation_done_pin)
		else $error("status not cleared by read");
	a_irq_none: assert property (!(link_active_pin || pending_deactivation_pin
		|| deactivation_done_pin) |-> !irq)
		else $error("interrupt with no event");
	a_gain_on: assert property (write && !waitrequest && address == 8'h24
		&& byteenable[0] && writedata[3:0] == 4'hF |-> ##2 rx_gain_boost)
		else $error("gain boost missing");
endmodule : dls_status_readout_asserts

// ### verification/dls_status_readout_tb.sv
// Self-checking bench for the link status readout
`timescale 1ns/1ps
module dls_status_readout_tb;
	import dls_pkg::*;
	// Stimulus
	logic clk = 0, rst = 1, read = 0, write = 0, baud_tick = 0, tmr = 0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hF;
	logic [15:0] agc_tap_main = 16'h0, sig = 16'h1, err = 16'h1;
	dls_link_t link_state = DLS_INACTIVE;
	// Observed outputs
	logic [31:0] readdata;
	logic waitrequest, irq, pin_d, pin_p, pin_a, rx_gain_boost;
	logic [7:0] nm_fsm, r;
	// Model state: latched status, mask, margin
	int n_fail = 0, n_tests = 0, mst = 0, mk = 0, nm = 0;
	int unsigned seed = 65198, x;
	always #20 clk = ~clk;
	dls_status_readout dls_status_readout_inst (.clk(clk), .rst(rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.link_state(link_state), .deact_timer_expired(tmr),
		.baud_tick(baud_tick), .agc_tap_main(agc_tap_main),
		.rx_signal_energy(sig), .rx_error_energy(err), .irq(irq),
		.deactivation_done_pin(pin_d), .pending_deactivation_pin(pin_p),
		.link_active_pin(pin_a), .rx_gain_boost(rx_gain_boost),
		.noise_margin_fsm(nm_fsm));
	task results;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Half-octave log: twice the top bit index plus the next bit
	function automatic int lh(input logic [15:0] v);
		int m;
		m = 0;
		for (int k = 1; k < 16; k++)
			if (v[k])
				m = k;
		return 2 * m + ((m > 0) ? v[m-1] : 0);
	endfunction : lh
	function automatic int pb(input dls_link_t s);
		return (s == DLS_ACTIVE) ? 1 : (s == DLS_PENDING) ? 2 :
			(s == DLS_DEACTIVATED) ? 4 : 0;
	endfunction : pb
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// One bus cycle; held until waitrequest samples low
	task acc(input logic w, input logic [7:0] a, d, input logic [3:0] be);
		int i;
		@(posedge clk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (waitrequest !== 1'b0 && i < 50);
		if (waitrequest === 1'b0) begin
			r = readdata[7:0];
			read <= 0;
			write <= 0;
			@(negedge clk);
		end else begin
			n_fail++;
			results();
		end
	endtask : acc
	task rd(input logic [7:0] a, e);
		acc(0, a, 8'h00, 4'hF);
		chk(r, e);
	endtask : rd
	// Interrupt and pins against the model
	task ci;
		@(negedge clk);
		chk(8'(irq), 8'((mst & ~mk) != 0));
		chk({5'h0, pin_d, pin_p, pin_a}, mst[7:0]);
	endtask : ci
	// Status read: returned bits clear unless their state persists
	task rd_st;
		int e;
		e = mst;
		rd(8'h00, e[7:0]);
		mst = pb(link_state) & (e | 3);
		ci;
	endtask : rd_st
	task wm(input logic [7:0] d, input logic [3:0] be);
		acc(1, 8'h20, d, be);
		if (be[0])
			mk = d;
		ci;
	endtask : wm
	task go(input dls_link_t s);
		@(posedge clk);
		link_state <= s;
		tmr <= (s == DLS_DEACTIVATED);
		@(posedge clk);
		tmr <= 0;
		mst |= pb(s);
		ci;
	endtask : go
	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			baud_tick <= 1;
			@(posedge clk);
			baud_tick <= 0;
		end
	endtask : tick
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		// Margin stays until the 64th baud, then follows the energies
		for (int k = 0; k < 3; k++) begin
			x = xs();
			agc_tap_main <= x[15:0];
			sig <= x[31:16] | 16'h1;
			x = xs();
			err <= x[15:0] | 16'h1;
			tick(63);
			rd(8'h08, nm[7:0]);
			rd(8'h04, {1'b0, agc_tap_main[14:8]});
			acc(1, 8'h04, 8'hFF, 4'hF);
			rd(8'h04, {1'b0, agc_tap_main[14:8]});
			tick(1);
			nm = 3 * (lh(sig) - lh(err));
			rd(8'h08, nm[7:0]);
			chk(nm_fsm, nm[7:0]);
		end
		rd(8'h14, 8'h00);
		acc(1, 8'h24, 8'h0F, 4'hF);
		// Boost flag is registered one edge after the gain write lands
		@(negedge clk);
		chk(8'(rx_gain_boost), 8'h01);
		acc(1, 8'h24, 8'h0E, 4'hF);
		@(negedge clk);
		chk(8'(rx_gain_boost), 8'h00);
		rd_st;
		go(DLS_ACTIVE);
		wm(8'h01, 4'hF);
		wm(8'h00, 4'hF);
		rd_st;
		rd_st;
		wm(8'h02, 4'hF);
		go(DLS_PENDING);
		rd_st;
		rd_st;
		wm(8'h04, 4'hF);
		wm(8'h07, 4'h0);
		go(DLS_DEACTIVATED);
		rd_st;
		rd_st;
		wm(8'h00, 4'hF);
		go(DLS_INACTIVE);
		rd_st;
		rd_st;
		results();
	end
endmodule : dls_status_readout_tb
bind dls_status_readout dls_status_readout_asserts dls_status_readout_asserts_inst (
	.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .link_state(link_state),
	.deact_timer_expired(deact_timer_expired), .irq(irq),
	.deactivation_done_pin(deactivation_done_pin),
	.pending_deactivation_pin(pending_deactivation_pin),
	.link_active_pin(link_active_pin), .rx_gain_boost(rx_gain_boost));
